// file: rtl/msf_defines.svh
/*
  constants for the measurement scheduler and current filters: register
  offsets, field positions, reset values and timing counts.
  assumes a 125 MHz core clock.
*/
`ifndef MSF_DEFINES_SVH
`define MSF_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define MSF_CLK_MHZ          125
`define MSF_SLOT_US          3000
`define MSF_SLOT_FAST_US     1500
`define MSF_SLOT_CYC         (`MSF_SLOT_US * `MSF_CLK_MHZ)
`define MSF_SLOT_FAST_CYC    (`MSF_SLOT_FAST_US * `MSF_CLK_MHZ)
`define MSF_INTEG_MS         250
`define MSF_INTEG_CYC        (`MSF_INTEG_MS * 1000 * `MSF_CLK_MHZ)
`define MSF_SEC_CYC          (1000000 * `MSF_CLK_MHZ)
`define MSF_LOOP_BASE_SLOTS  21
`define MSF_CELLS            14
`define MSF_EXT_MAX          3

// ****************************************************************
// register offsets
// ****************************************************************
`define MSF_REG_CONFIG       8'h00
`define MSF_REG_COMMAND      8'h04
`define MSF_REG_STATUS       8'h08
`define MSF_REG_CUR_REPORT   8'h0C
`define MSF_REG_CUR_INTEG    8'h10
`define MSF_REG_CUR_AVG      8'h14
`define MSF_REG_AVG_COUNTS   8'h18
`define MSF_REG_REP_COUNTS   8'h1C
`define MSF_REG_CHARGE_LO    8'h20
`define MSF_REG_CHARGE_HI    8'h24
`define MSF_REG_CHARGE_TIME  8'h28
`define MSF_REG_AUX_MV       8'h2C
`define MSF_REG_AUX_COUNTS   8'h30
`define MSF_REG_INTERCONNECT 8'h34
`define MSF_REG_CELL_BASE    8'h40
`define MSF_REG_COUNT_BASE   8'h80

// ****************************************************************
// config fields and reset value
// ****************************************************************
`define MSF_CFG_FAST         0
`define MSF_CFG_LOOP_LO      1
`define MSF_CFG_UNIT_LO      3
`define MSF_CFG_EXT_LO       5
`define MSF_CFG_AVG_LO       8
`define MSF_CFG_USAGE_LO     16
`define MSF_CFG_RESET        32'h0000_0A00
`define MSF_CMD_CLEAR_CHARGE 16'h0082

`endif

// file: rtl/msf_pkg.sv
/*
  types for the measurement scheduler.
  assumes msf_defines.svh is included by the users.
*/
`default_nettype none
package msf_pkg;
  typedef enum logic [1:0] {
    MSF_CELL  = 2'b00,
    MSF_PIN   = 2'b01,
    MSF_MISC  = 2'b11,
    MSF_IDLE  = 2'b10
  } msf_phase_t;
endpackage
`default_nettype wire

// file: rtl/msf_scheduler.sv
/*
  measurement loop scheduler with current filters and charge counter.
  assumes a voltage converter that answers each adc_start_o with a 24-bit result
  on adc_done_i and a current converter that strobes cc_valid_i.
*/
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
// Function
// - fourteen cells, then one pin-voltage slot
// - internal slot, two unused, up to three external
// - full measurement set every three loops
// - loop is 18 to 21 slots by inputs
// - slot 3 ms, 1.5 ms when fast
// - idle current-only slots appended after measurements
// - loop times 63, 126, 252, 504 ms with 3 ms slots and three external inputs
// - usage mask disables protection on non-cells
// - cells and first external input reported in mV and counts
// - subtract current times interconnect resistance
// - general input returns signed millivolts
// - first thermistor raw counts stored
// - current unit select scales current reports
// - integration result every 250 ms
// - reporting result every slot period
// - 24-bit counts sign-extended to 32 bits
// - average of up to 255 samples
// - 64-bit charge plus 32-bit seconds timer
// - clear command resets charge and timer
// - little-endian byte order, two's complement
`include "msf_defines.svh"
`default_nettype none
module msf_scheduler #(
  parameter int SLOT_CYC      = `MSF_SLOT_CYC,
  parameter int SLOT_FAST_CYC = `MSF_SLOT_FAST_CYC,
  parameter int INTEG_CYC     = `MSF_INTEG_CYC,
  parameter int SEC_CYC       = `MSF_SEC_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        adc_done_i,
  input  wire logic [23:0] adc_data_i,
  input  wire logic        cc_valid_i,
  input  wire logic [23:0] cc_data_i,
  output logic             adc_start_o,
  output logic [4:0]       adc_channel_o,
  output logic [13:0]      cell_protect_en_o,
  output logic             slot_strobe_o
);
  // refuse counts too short for the strobe and window logic
  if (SLOT_CYC < 4 || SLOT_FAST_CYC < 4 ||
      INTEG_CYC < 4 || SEC_CYC < 4) begin : g_bad_counts
    $error("msf_scheduler: counts too small");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              aw_hold, w_hold;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [31:0]       cfg;
    logic [7:0]        icr;
    msf_pkg::msf_phase_t phase;
    logic [4:0]        slot;
    logic [7:0]        idle_left;
    logic [1:0]        rot;
    logic [31:0]       slot_cnt;
    logic              start, strobe;
    logic [4:0]        chan;
    logic [31:0]       integ_cnt, sec_cnt;
    logic [31:0]       integ_n;
    logic signed [31:0] rep_raw, integ_acc, integ_out, avg_out, avg_sum;
    logic [7:0]        avg_n;
    logic [63:0]       charge;
    logic [31:0]       charge_time;
    logic [15:0]       aux_mv;
    logic [31:0]       aux_counts;
  } msf_state_t;

  msf_state_t st;
  msf_state_t next_st;
  logic [15:0] cell_mv [14];
  logic [31:0] cell_cnt [14];

  function automatic logic signed [31:0] sx24(input logic [23:0] d);
    sx24 = {{8{d[23]}}, d};
  endfunction

  // scale raw counts to the selected unit: shift right by two bits per unit step
  function automatic logic [15:0] scale(input logic signed [31:0] v,
                                        input logic [1:0] u);
    logic signed [31:0] s;
    s = v >>> {u, 1'b0};
    scale = s[15:0];
  endfunction

  logic [1:0] ext_n;
  logic [4:0] meas_slots;
  logic [7:0] idle_slots;
  logic [31:0] slot_len;
  logic signed [31:0] drop;
  assign ext_n = st.cfg[`MSF_CFG_EXT_LO +: 2];
  // 18 fixed slots plus one per enabled external input
  assign meas_slots = 5'd18 + {3'b000, ext_n};
  // idle slots add 0, 21, 63 or 147 slots, so a 21-slot loop grows to 21 * 2^sel
  always_comb begin
    unique case (st.cfg[`MSF_CFG_LOOP_LO +: 2])
      2'b00: idle_slots = 8'h00;
      2'b01: idle_slots = 8'h15;
      2'b10: idle_slots = 8'h3F;
      2'b11: idle_slots = 8'h93;
    endcase
  end
  assign slot_len = st.cfg[`MSF_CFG_FAST] ? SLOT_FAST_CYC : SLOT_CYC;
  assign drop = st.rep_raw * $signed({24'h0, st.icr});

  always_comb begin
    logic [7:0] a;
    next_st = st;
    a = 8'h00;
    next_st.start = 1'b0;
    next_st.strobe = 1'b0;
    // bus write: address and data in either order
    if (s_axi_awvalid_i && st.awready) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr_i;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid_i && st.wready) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata_i;
      next_st.wready = 1'b0;
    end
    if (st.aw_hold && st.w_hold && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'b00;
      unique case (st.aw_addr)
        `MSF_REG_CONFIG: next_st.cfg = st.w_data;
        `MSF_REG_INTERCONNECT: next_st.icr = st.w_data[7:0];
        `MSF_REG_COMMAND: ;
        default: next_st.bresp = 2'b10;
      endcase
    end
    if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    // bus read, little-endian words
    if (s_axi_arvalid_i && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'b00;
      a = s_axi_araddr_i;
      if (a >= `MSF_REG_COUNT_BASE && a < 8'hB8)
        next_st.rdata = cell_cnt[4'((a - 8'h80) >> 2)];
      else if (a >= `MSF_REG_CELL_BASE && a < 8'h78)
        next_st.rdata = {16'h0, cell_mv[4'((a - 8'h40) >> 2)]};
      else begin
        unique case (a)
          `MSF_REG_CONFIG:      next_st.rdata = st.cfg;
          `MSF_REG_STATUS:
            next_st.rdata = {19'h0, st.rot, st.slot, 4'h0, st.phase};
          `MSF_REG_CUR_REPORT:
            next_st.rdata = {16'h0, scale(st.rep_raw, st.cfg[4:3])};
          `MSF_REG_CUR_INTEG:
            next_st.rdata = {16'h0, scale(st.integ_out, st.cfg[4:3])};
          `MSF_REG_CUR_AVG:
            next_st.rdata = {16'h0, scale(st.avg_out, st.cfg[4:3])};
          `MSF_REG_AVG_COUNTS:  next_st.rdata = st.avg_out;
          `MSF_REG_REP_COUNTS:  next_st.rdata = st.rep_raw;
          `MSF_REG_CHARGE_LO:   next_st.rdata = st.charge[31:0];
          `MSF_REG_CHARGE_HI:   next_st.rdata = st.charge[63:32];
          `MSF_REG_CHARGE_TIME: next_st.rdata = st.charge_time;
          `MSF_REG_AUX_MV:      next_st.rdata = {16'h0, st.aux_mv};
          `MSF_REG_AUX_COUNTS:  next_st.rdata = st.aux_counts;
          `MSF_REG_INTERCONNECT: next_st.rdata = {24'h0, st.icr};
          default: begin
            next_st.rdata = 32'h0;
            next_st.rresp = 2'b10;
          end
        endcase
      end
    end
    if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // ****************************************************************
    // slot sequencer
    // ****************************************************************
    next_st.slot_cnt = st.slot_cnt + 32'h1;
    if (st.slot_cnt >= slot_len - 32'h1) begin
      next_st.slot_cnt = 32'h0;
      next_st.strobe = 1'b1;
      if (st.phase == msf_pkg::MSF_IDLE) begin
        if (st.idle_left <= 8'h1) begin
          next_st.phase = msf_pkg::MSF_CELL;
          next_st.slot = 5'h0;
        end
        next_st.idle_left = st.idle_left - 8'h1;
      end else if (st.slot >= meas_slots - 5'h1) begin
        // >= so a shorter loop set mid-loop still wraps
        next_st.rot = (st.rot == 2'h2) ? 2'h0 : st.rot + 2'h1;
        next_st.slot = 5'h0;
        if (idle_slots != 8'h0) begin
          next_st.phase = msf_pkg::MSF_IDLE;
          next_st.idle_left = idle_slots;
        end else
          next_st.phase = msf_pkg::MSF_CELL;
      end else begin
        next_st.slot = st.slot + 5'h1;
        // cells, then pin, internal, unused, external
        next_st.phase = (st.slot + 5'h1 < 5'd14) ? msf_pkg::MSF_CELL :
                        (st.slot + 5'h1 == 5'd14) ? msf_pkg::MSF_PIN :
                        msf_pkg::MSF_MISC;
      end
      if (next_st.phase != msf_pkg::MSF_IDLE) begin
        // unused slots 16 and 17 start nothing
        next_st.start = !(next_st.slot == 5'd16 || next_st.slot == 5'd17);
        // pin and internal slots add rotation to pick their candidate
        next_st.chan = (next_st.slot == 5'd14 || next_st.slot == 5'd15) ?
                       next_st.slot + 5'({next_st.rot, 3'b000}) :
                       next_st.slot;
      end
    end

    // ****************************************************************
    // current filters, independent of loop phase
    // ****************************************************************
    next_st.integ_cnt = st.integ_cnt + 32'h1;
    next_st.sec_cnt = st.sec_cnt + 32'h1;
    if (cc_valid_i) begin
      next_st.rep_raw = sx24(cc_data_i);
      next_st.integ_acc = st.integ_acc + sx24(cc_data_i);
      next_st.integ_n = st.integ_n + 32'h1;
      next_st.avg_sum = st.avg_sum + sx24(cc_data_i);
      next_st.avg_n = st.avg_n + 8'h1;
      if (st.avg_n + 8'h1 >= st.cfg[`MSF_CFG_AVG_LO +: 8]) begin
        next_st.avg_out = st.avg_sum + sx24(cc_data_i); // mean below
        next_st.avg_out = next_st.avg_out /
                          $signed({24'h0, st.avg_n + 8'h1});
        next_st.avg_sum = 32'sh0;
        next_st.avg_n = 8'h0;
      end
    end
    if (st.integ_cnt >= 32'(INTEG_CYC - 1)) begin
      next_st.integ_cnt = 32'h0;
      // window sum feeds the charge; the report is the window mean
      next_st.charge = st.charge + 64'(signed'(next_st.integ_acc));
      next_st.integ_out = (next_st.integ_n == 32'h0) ? 32'sh0 :
                          next_st.integ_acc / $signed(next_st.integ_n);
      next_st.integ_acc = 32'sh0;
      next_st.integ_n = 32'h0;
    end
    if (st.sec_cnt >= 32'(SEC_CYC - 1)) begin
      next_st.sec_cnt = 32'h0;
      next_st.charge_time = st.charge_time + 32'h1;
    end
    // clear command wins over a same-cycle accumulation
    if (st.aw_hold && st.w_hold && !st.bvalid &&
        st.aw_addr == `MSF_REG_COMMAND &&
        st.w_data[15:0] == `MSF_CMD_CLEAR_CHARGE) begin
      next_st.charge = 64'h0;
      next_st.charge_time = 32'h0;
      next_st.sec_cnt = 32'h0;
    end
    // first external slot is the first thermistor pin
    if (adc_done_i && st.chan == 5'd18) begin
      next_st.aux_counts = sx24(adc_data_i);
      next_st.aux_mv = adc_data_i[23:8];
    end
    if (reset_i) begin
      next_st = '0;
      // one lead-in idle slot so the first loop starts at cell 0
      next_st.phase = msf_pkg::MSF_IDLE;
      next_st.idle_left = 8'h1;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
      next_st.cfg = `MSF_CFG_RESET;
    end
  end

  // cell result store, one entry per input
  for (genvar i = 0; i < 14; i++) begin : g_cell
    always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
        cell_mv[i] <= 16'h0;
        cell_cnt[i] <= 32'h0;
      end else if (adc_done_i && st.chan == 5'(i)) begin
        cell_cnt[i] <= sx24(adc_data_i);
        cell_mv[i] <= 16'((sx24(adc_data_i) - drop) >>> 8);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
    // protection only where usage marks a real cell
    cell_protect_en_o <= reset_i ? 14'h0 : next_st.cfg[`MSF_CFG_USAGE_LO +: 14];
  end

  assign s_axi_awready_o = st.awready;
  assign s_axi_wready_o  = st.wready;
  assign s_axi_bvalid_o  = st.bvalid;
  assign s_axi_bresp_o   = st.bresp;
  assign s_axi_arready_o = st.arready;
  assign s_axi_rvalid_o  = st.rvalid;
  assign s_axi_rresp_o   = st.rresp;
  assign s_axi_rdata_o   = st.rdata;
  assign adc_start_o     = st.start;
  assign adc_channel_o   = st.chan;
  assign slot_strobe_o   = st.strobe;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_loop_end;
    st.strobe && st.slot == 5'h0;
  endsequence
  AST_UNUSED_NO_START: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.start |-> !(st.chan == 5'd16 || st.chan == 5'd17))
    else $error("start issued in unused slot");
  AST_ROT_RANGE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.rot != 2'h3)
    else $error("rotation out of range");
  AST_SLOT_RANGE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.slot < 5'd21)
    else $error("slot index beyond loop");
  AST_CELL_PHASE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.phase == msf_pkg::MSF_CELL |-> st.slot < 5'd14)
    else $error("cell phase outside cell slots");
  AST_IDLE_NO_START: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.phase == msf_pkg::MSF_IDLE |-> !st.start)
    else $error("conversion started in idle slot");
  AST_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (st.aw_hold && st.w_hold && !st.bvalid && st.aw_addr == 8'h04 &&
     st.w_data[15:0] == 16'h0082) |=> st.charge_time == 32'h0)
    else $error("charge timer not cleared");
  AST_REP: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !reset_i && cc_valid_i |=>
      st.rep_raw == {{8{$past(cc_data_i[23])}}, $past(cc_data_i)})
    else $error("reporting value not sign extended");
  AST_SLOT_GAP: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_loop_end |=> !st.strobe)
    else $error("slot strobes back to back");
  AST_PROTECT: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 cell_protect_en_o == $past(next_st.cfg[29:16]))
    else $error("protection mask mismatch");
endmodule
`default_nettype wire

// file: dv/tb_measurement_scheduler_current_filters.sv
/*
  self-checking bench for msf_scheduler: axi4-lite register tasks, a
  converter stand-in that answers each start one cycle later, and a
  current sample stream every fifth cycle.
  assumes the shortened slot, integration and second counts set below.
*/
`include "msf_defines.svh"
`default_nettype none
module tb_measurement_scheduler_current_filters;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT  = 20;
  localparam int SLOTF = 10;
  `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end end
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, strobe;
  logic        adc_done, cc_valid, adc_start;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [23:0] adc_data, cc_data, cc_val;
  logic [4:0]  chan;
  logic [13:0] prot;
  int          n_mismatch, check_count, cyc, zero_cnt;
  logic [4:0]  ch_q[$];
  int          cyc_q[$];

  msf_scheduler #(.SLOT_CYC(SLOT), .SLOT_FAST_CYC(SLOTF), .INTEG_CYC(50),
                  .SEC_CYC(100)) DUT (
    .core_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .adc_done_i(adc_done), .adc_data_i(adc_data), .cc_valid_i(cc_valid),
    .cc_data_i(cc_data), .adc_start_o(adc_start), .adc_channel_o(chan),
    .cell_protect_en_o(prot), .slot_strobe_o(strobe)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // odd channels read back negative so sign extension is exercised
  function automatic logic [23:0] adc_val(input logic [4:0] c);
    return c[0] ? {19'h7C000, c} : {19'h02A00, c};
  endfunction
  function automatic logic [31:0] sx(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction
  function automatic logic [31:0] cfg(input logic f, input logic [1:0] r,
      input logic [1:0] u, input logic [1:0] e);
    return {2'b00, 14'h2AB5, 8'h04, 1'b0, e, u, r, f};
  endfunction
  function automatic int nth_zero(input int from, input int k);
    int i;
    for (i = from; i < ch_q.size(); i++) begin
      if (ch_q[i] == 5'h00) begin
        k--;
        if (k == 0) return i;
      end
    end
    return 0;
  endfunction

  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic timed_out;
    n_mismatch++;
    report_and_stop();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (ad && wd && bvalid) begin
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
        break;
      end
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (n == 200) timed_out();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    int n;
    logic ad;
    ad = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (ad && rvalid) begin
        `CHK("rdata", e, rdata)
        `CHK("rresp", er, rresp)
        rready <= 1'b0;
        break;
      end
      if (!ad && arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
    end
    if (n == 200) timed_out();
  endtask
  task automatic wait_zeros(input int k);
    int n, base;
    base = zero_cnt;
    for (n = 0; n < 30000 && zero_cnt - base < k; n++) @(posedge clk);
    if (n == 30000) timed_out();
  endtask

  // ****************************************************************
  // clock, reset, converter stand-in and start recorder
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {adc_done, cc_valid, adc_data, cc_data} = '0;
    {n_mismatch, check_count, cyc, zero_cnt} = '0;
    cc_val = 24'hFF0000;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  end
  // current samples keep flowing in idle slots as well
  always @(posedge clk) begin
    cyc      <= cyc + 1;
    adc_done <= adc_start;
    adc_data <= adc_val(chan);
    cc_valid <= (cyc % 5 == 0);
    cc_data  <= cc_val;
    if (!rst && adc_start) begin
      ch_q.push_back(chan);
      cyc_q.push_back(cyc);
      if (chan == 5'h00) zero_cnt <= zero_cnt + 1;
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin : main
    int k, j, i, qb, r, e, sl;
    int rates[5] = '{0, 1, 2, 3, 0};
    int exts[5]  = '{3, 3, 3, 3, 1};
    @(negedge rst);
    axi_wr(`MSF_REG_COMMAND, 32'(`MSF_CMD_CLEAR_CHARGE), 2'b00);
    `CHK("protect", 14'h0000, prot)
    rd_chk(`MSF_REG_CONFIG, `MSF_CFG_RESET, 2'b00);
    wait_zeros(4);
    for (k = 0; k < 3; k++) begin
      for (j = 0; j < 14; j++) `CHK("cell", 5'(j), ch_q[16*k+j])
      `CHK("pin", 5'(14 + 8*k), ch_q[16*k+14])
      `CHK("misc", 5'(15 + 8*k), ch_q[16*k+15])
      `CHK("loop", 18*SLOT, cyc_q[16*k+16] - cyc_q[16*k])
    end
    rd_chk(8'h3C, 32'h0, 2'b10);
    axi_wr(8'h38, 32'h1, 2'b10);
    for (k = 0; k < 5; k++) begin
      r  = rates[k];
      e  = exts[k];
      sl = (r % 2 == 1) ? SLOTF : SLOT;
      axi_wr(`MSF_REG_CONFIG, cfg(1'(r % 2), 2'(r), 2'd0, 2'(e)), 2'b00);
      `CHK("protect", 14'h2AB5, prot)
      rd_chk(`MSF_REG_CONFIG, cfg(1'(r % 2), 2'(r), 2'd0, 2'(e)), 2'b00);
      qb = ch_q.size();
      wait_zeros(5);
      i = nth_zero(qb, 3);
      for (j = 0; j < 14; j++) `CHK("cell", 5'(j), ch_q[i+j])
      for (j = 0; j < e; j++) `CHK("ext", 5'(18 + j), ch_q[i+16+j])
      `CHK("wrap", 5'h00, ch_q[i+16+e])
      `CHK("cycle", (18 + e)*sl << r, cyc_q[i+16+e] - cyc_q[i])
      `CHK("idle", 1'b1, cyc_q[i+15+e] - cyc_q[i] < (18 + e)*sl)
      `CHK("slot", 1'b1, cyc_q[i+1] - cyc_q[i] == sl)
    end
    for (j = 0; j < 14; j++) begin
      rd_chk(8'(`MSF_REG_COUNT_BASE + 4*j), sx(adc_val(5'(j))), 2'b00);
    end
    rd_chk(`MSF_REG_AUX_COUNTS, sx(adc_val(5'd18)), 2'b00);
    rd_chk(`MSF_REG_REP_COUNTS, 32'hFFFF0000, 2'b00);
    rd_chk(`MSF_REG_AVG_COUNTS, 32'hFFFF0000, 2'b00);
    cc_val = 24'h004000;
    for (k = 0; k < 4; k++) begin
      axi_wr(`MSF_REG_CONFIG, cfg(1'b0, 2'd0, 2'(k), 2'd1), 2'b00);
      repeat (120) @(posedge clk);
      rd_chk(`MSF_REG_CUR_REPORT, 32'(16384 >> (2*k)), 2'b00);
      rd_chk(`MSF_REG_CUR_AVG, 32'(16384 >> (2*k)), 2'b00);
      rd_chk(`MSF_REG_CUR_INTEG, 32'(16384 >> (2*k)), 2'b00);
    end
    // cell 0 less 16384 times 4 mOhm, in 256-count mV steps
    axi_wr(`MSF_REG_INTERCONNECT, 32'h0000_0004, 2'b00);
    repeat (400) @(posedge clk);
    rd_chk(`MSF_REG_CELL_BASE, 32'h0000_0440, 2'b00);
    // let the integration result settle at zero so no charge is added
    cc_val = 24'h000000;
    repeat (150) @(posedge clk);
    axi_wr(`MSF_REG_COMMAND, 32'(`MSF_CMD_CLEAR_CHARGE), 2'b00);
    rd_chk(`MSF_REG_CHARGE_TIME, 32'h0, 2'b00);
    rd_chk(`MSF_REG_CHARGE_LO, 32'h0, 2'b00);
    rd_chk(`MSF_REG_CHARGE_HI, 32'h0, 2'b00);
    repeat (250) @(posedge clk);
    rd_chk(`MSF_REG_CHARGE_TIME, 32'h2, 2'b00);
    report_and_stop();
  end
  `undef CHK
endmodule
`default_nettype wire
